// *** spm_params.svh ***
// Register offsets, field positions, reset values and timing constants of the sleep power sequencer
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH
`define SPM_OFF_SLEEP_CTL 8'h00
`define SPM_OFF_WAKE_CTL  8'h04
`define SPM_OFF_STATUS    8'h08
`define SPM_OFF_TIMEOUT   8'h0c
`define SPM_OFF_COUNT     8'h10
`define SPM_OFF_OPTIONS   8'h14
`define SPM_SC_DEEP       0
`define SPM_SC_LIGHT      1
`define SPM_WC_TMR_EN     0
`define SPM_WC_RTC_EN     1
`define SPM_WC_TMR_IEN    16
`define SPM_ST_SYNC       0
`define SPM_ST_DEEP_EVT   1
`define SPM_ST_LIGHT_EVT  2
`define SPM_ST_TMR_EVT    4
`define SPM_OPT_RETAIN    0
`define SPM_OPT_RADIO     1
`define SPM_OPT_PRESC_LSB 4
`define SPM_PWR_RUN       9'h1ff
`define SPM_CLK_MHZ       125
`define SPM_OSC_WAIT_US   700
`define SPM_CPU_RST_US    40
`define SPM_LIGHT_DIV     128
`define SPM_DEEP_DIV      62500
`endif

// *** spm_pkg.sv ***
// Types shared by the sleep power sequencer modules
`default_nettype none
package spm_pkg;
  typedef enum logic [3:0] {
    SPM_RUN         = 4'h0,
    SPM_DEEP_PRE    = 4'h1,
    SPM_DEEP_SLEEP  = 4'h2,
    SPM_DEEP_OSC    = 4'h3,
    SPM_DEEP_WAKE1  = 4'h4,
    SPM_DEEP_WAKE2  = 4'h5,
    SPM_DEEP_WAKE3  = 4'h6,
    SPM_LIGHT_PRE   = 4'h7,
    SPM_LIGHT_SLEEP = 4'h8,
    SPM_LIGHT_OSC   = 4'h9,
    SPM_LIGHT_WAKE1 = 4'ha,
    SPM_LIGHT_WAKE2 = 4'hb,
    SPM_LIGHT_WAKE3 = 4'hc
  } spm_state_t;
endpackage
`default_nettype wire

// *** spm_tmr_if.sv ***
// Signals between the sequencer and its wake timer
`timescale 1ns/100ps
`default_nettype none
interface spm_tmr_if;
  logic        active;
  logic        deep;
  logic        restart;
  logic [31:0] timeout;
  logic        tick;
  logic        evt;
  logic [31:0] count;
  modport ctl (output active, deep, restart, timeout, input tick, evt, count);
  modport tmr (input active, deep, restart, timeout, output tick, evt, count);
endinterface
`default_nettype wire

// *** spm_wake_timer.sv ***
// Sleep clock tick divider and 32-bit wake timer
`timescale 1ns/100ps
`default_nettype none
`include "spm_params.svh"
module spm_wake_timer #(
  parameter int DEEP_TICK_DIV = `SPM_DEEP_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  spm_tmr_if.tmr   t
);
  logic [15:0] div_q;
  logic [15:0] div_lim;
  logic        tick_q;
  logic [31:0] count_q;
  logic        evt_q;

  // Tick period follows the active sleep mode
  assign div_lim = t.deep ? 16'(DEEP_TICK_DIV - 1) : 16'(`SPM_LIGHT_DIV - 1);
  assign t.tick  = tick_q;
  assign t.count = count_q;
  assign t.evt   = evt_q;

  // Divider, held while running or on restart
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end
    else if (!t.active || t.restart)
    begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q >= div_lim);
      div_q  <= (div_q >= div_lim) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // Counter counts ticks only outside run
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= 32'h0000_0000;
    else if (t.restart)
      count_q <= 32'h0000_0000;
    else if (t.active && tick_q)
      count_q <= count_q + 32'h0000_0001;
  end

  // Match on the tick where count equals timeout
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      evt_q <= 1'b0;
    else
      evt_q <= t.active && tick_q && !t.restart && (count_q == t.timeout);
  end
endmodule
`default_nettype wire

// *** spm_sequencer.sv ***
// Sleep power mode sequencer with APB registers
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "spm_params.svh"
module spm_sequencer #(
  parameter int DEEP_TICK_DIV = `SPM_DEEP_DIV,
  parameter int OSC_WAIT_CYC  = `SPM_OSC_WAIT_US * `SPM_CLK_MHZ,
  parameter int CPU_RST_CYC   = `SPM_CPU_RST_US * `SPM_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RST_N_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Wake sources
  input  wire logic        EXT_WAKE_IN,
  input  wire logic        RTC_TIMEOUT_IN,
  // Power and clock controls
  output logic             VREF_EN_OUT,
  output logic             REFOSC_REG_EN_OUT,
  output logic             REFOSC_EN_OUT,
  output logic             DIG_REG_EN_OUT,
  output logic             CPU_RAM_CONNECT_OUT,
  output logic             PAD_RING_EN_OUT,
  output logic             SEQ_CLK_REF_OUT,
  output logic             CPU_CLK_EN_OUT,
  output logic             MODEM_ACCEL_CLK_EN_OUT,
  output logic             CPU_RST_OUT,
  output logic             RADIO_EN_OUT,
  output logic      [3:0]  CPU_PRESC_OUT,
  output logic             WAKE_TIMER_IRQ_OUT
);
  spm_pkg::spm_state_t state_q;
  logic [1:0]  sc_q;
  logic        tmr_en_q;
  logic        rtc_en_q;
  logic        ien_q;
  logic        sync_q;
  logic        deep_evt_q;
  logic        light_evt_q;
  logic        tmr_evt_q;
  logic        retain_q;
  logic        radio_q;
  logic [3:0]  presc_q;
  logic [31:0] timeout_q;
  logic        armed_q;
  logic [16:0] wait_q;
  logic [8:0]  pwr_q;
  logic        cpu_rst_q;
  logic        irq_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        acc;
  logic        wr;
  logic [2:0]  widx;
  logic        pre_st;
  logic        w3_st;
  logic        sync_set;
  logic        sync_clr;
  logic        timed_wake;
  logic        wake;
  spm_tmr_if   tif ();

  // Register index of an address, 7 when unmapped
  function automatic logic [2:0] spm_idx(input logic [7:0] a);
    case (a)
      `SPM_OFF_SLEEP_CTL: spm_idx = 3'h0;
      `SPM_OFF_WAKE_CTL:  spm_idx = 3'h1;
      `SPM_OFF_STATUS:    spm_idx = 3'h2;
      `SPM_OFF_TIMEOUT:   spm_idx = 3'h3;
      `SPM_OFF_COUNT:     spm_idx = 3'h4;
      `SPM_OFF_OPTIONS:   spm_idx = 3'h5;
      default:            spm_idx = 3'h7;
    endcase
  endfunction

  // Power and clock enables for each state
  function automatic logic [8:0] spm_pwr(input spm_pkg::spm_state_t s);
    case (s)
      spm_pkg::SPM_DEEP_SLEEP:  spm_pwr = 9'h000;
      spm_pkg::SPM_LIGHT_SLEEP: spm_pwr = 9'h006;
      spm_pkg::SPM_DEEP_OSC:    spm_pwr = 9'h007;
      spm_pkg::SPM_LIGHT_OSC:   spm_pwr = 9'h007;
      spm_pkg::SPM_DEEP_WAKE1,
      spm_pkg::SPM_DEEP_WAKE2:  spm_pwr = 9'h07f;
      spm_pkg::SPM_LIGHT_WAKE1,
      spm_pkg::SPM_LIGHT_WAKE2: spm_pwr = 9'h03f;
      spm_pkg::SPM_DEEP_WAKE3:  spm_pwr = 9'h0ff;
      spm_pkg::SPM_LIGHT_WAKE3: spm_pwr = 9'h0bf;
      default:                  spm_pwr = `SPM_PWR_RUN;
    endcase
  endfunction

  // Wake timer
  spm_wake_timer #(.DEEP_TICK_DIV(DEEP_TICK_DIV)) u_timer (
    .clk   (MCLK_IN),
    .rst_n (RST_N_IN),
    .t     (tif.tmr)
  );

  // Timer control and wake qualification
  assign pre_st     = (state_q == spm_pkg::SPM_DEEP_PRE) || (state_q == spm_pkg::SPM_LIGHT_PRE);
  assign w3_st      = (state_q == spm_pkg::SPM_DEEP_WAKE3) || (state_q == spm_pkg::SPM_LIGHT_WAKE3);
  assign sync_set   = (pre_st || w3_st) && !armed_q && tif.tick;
  assign tif.active = (state_q != spm_pkg::SPM_RUN);
  assign tif.deep   = (state_q <= spm_pkg::SPM_DEEP_WAKE3);
  assign tif.restart = pre_st && sync_set;
  assign tif.timeout = timeout_q;
  assign timed_wake = (tmr_en_q && tif.evt) || (rtc_en_q && RTC_TIMEOUT_IN);
  assign wake       = timed_wake || EXT_WAKE_IN;

  // APB access decode
  assign acc  = PSEL_IN && PENABLE_IN && pready_q;
  assign wr   = acc && PWRITE_IN;
  assign widx = spm_idx(PADDR_IN);
  assign sync_clr = wr && (widx == 3'h2) && PWDATA_IN[`SPM_ST_SYNC];

  // APB answer one cycle after setup
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= PSEL_IN && !PENABLE_IN;
      pslverr_q <= PSEL_IN && !PENABLE_IN && (widx == 3'h7);
      if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
      begin
        case (widx)
          3'h0:    prdata_q <= {30'h0, sc_q};
          3'h1:    prdata_q <= {15'h0, ien_q, 14'h0, rtc_en_q, tmr_en_q};
          3'h2:    prdata_q <= {27'h0, tmr_evt_q, 1'b0, light_evt_q, deep_evt_q, sync_q};
          3'h3:    prdata_q <= timeout_q;
          3'h4:    prdata_q <= tif.count;
          3'h5:    prdata_q <= {24'h0, presc_q, 2'h0, radio_q, retain_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software configuration registers
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      tmr_en_q  <= 1'b0;
      rtc_en_q  <= 1'b0;
      ien_q     <= 1'b0;
      timeout_q <= 32'h0000_0000;
      retain_q  <= 1'b0;
    end
    else if (wr)
    begin
      if (widx == 3'h1)
      begin
        tmr_en_q <= PWDATA_IN[`SPM_WC_TMR_EN];
        rtc_en_q <= PWDATA_IN[`SPM_WC_RTC_EN];
        ien_q    <= PWDATA_IN[`SPM_WC_TMR_IEN];
      end
      if (widx == 3'h3)
        timeout_q <= PWDATA_IN;
      if (widx == 3'h5)
        retain_q <= PWDATA_IN[`SPM_OPT_RETAIN];
    end
  end

  // Radio and prescaler, forced to idle defaults on wake
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      radio_q <= 1'b0;
      presc_q <= 4'h0;
    end
    else if (w3_st && armed_q && !sync_q)
    begin
      radio_q <= 1'b0;
      presc_q <= 4'h0;
    end
    else if (wr && (widx == 3'h5))
    begin
      radio_q <= PWDATA_IN[`SPM_OPT_RADIO];
      presc_q <= PWDATA_IN[`SPM_OPT_PRESC_LSB +: 4];
    end
  end

  // Sleep requests, taken and cleared from run
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      sc_q <= 2'h0;
    else if (wr && (widx == 3'h0))
      sc_q <= PWDATA_IN[1:0];
    else if (state_q == spm_pkg::SPM_RUN)
      sc_q <= 2'h0;
  end

  // Status flags, hardware set wins over write-one clear
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      sync_q      <= 1'b0;
      deep_evt_q  <= 1'b0;
      light_evt_q <= 1'b0;
      tmr_evt_q   <= 1'b0;
    end
    else
    begin
      if (sync_set)
        sync_q <= 1'b1;
      else if (sync_clr)
        sync_q <= 1'b0;
      if ((state_q == spm_pkg::SPM_DEEP_SLEEP) && timed_wake)
        deep_evt_q <= 1'b1;
      else if (wr && (widx == 3'h2) && PWDATA_IN[`SPM_ST_DEEP_EVT])
        deep_evt_q <= 1'b0;
      if ((state_q == spm_pkg::SPM_LIGHT_SLEEP) && timed_wake)
        light_evt_q <= 1'b1;
      else if (wr && (widx == 3'h2) && PWDATA_IN[`SPM_ST_LIGHT_EVT])
        light_evt_q <= 1'b0;
      if (tif.evt)
        tmr_evt_q <= 1'b1;
      else if (wr && (widx == 3'h2) && PWDATA_IN[`SPM_ST_TMR_EVT])
        tmr_evt_q <= 1'b0;
    end
  end

  // Sequencer state and wait counter
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_q <= spm_pkg::SPM_RUN;
      armed_q <= 1'b0;
      wait_q  <= 17'h00000;
    end
    else
    begin
      if (sync_set)
        armed_q <= 1'b1;
      unique case (state_q)
        spm_pkg::SPM_RUN:
          if (sc_q[`SPM_SC_DEEP])
            state_q <= spm_pkg::SPM_DEEP_PRE;
          else if (sc_q[`SPM_SC_LIGHT])
            state_q <= spm_pkg::SPM_LIGHT_PRE;
        spm_pkg::SPM_DEEP_PRE, spm_pkg::SPM_LIGHT_PRE:
          if (armed_q && !sync_q)
          begin
            armed_q <= 1'b0;
            state_q <= (state_q == spm_pkg::SPM_DEEP_PRE) ? spm_pkg::SPM_DEEP_SLEEP
                                                          : spm_pkg::SPM_LIGHT_SLEEP;
          end
        spm_pkg::SPM_DEEP_SLEEP, spm_pkg::SPM_LIGHT_SLEEP:
          if (wake)
          begin
            wait_q  <= 17'(OSC_WAIT_CYC - 1);
            state_q <= (state_q == spm_pkg::SPM_DEEP_SLEEP) ? spm_pkg::SPM_DEEP_OSC
                                                            : spm_pkg::SPM_LIGHT_OSC;
          end
        spm_pkg::SPM_DEEP_OSC, spm_pkg::SPM_LIGHT_OSC:
          if (wait_q == 17'h00000)
            state_q <= (state_q == spm_pkg::SPM_DEEP_OSC) ? spm_pkg::SPM_DEEP_WAKE1
                                                          : spm_pkg::SPM_LIGHT_WAKE1;
          else
            wait_q <= wait_q - 17'h00001;
        spm_pkg::SPM_DEEP_WAKE1, spm_pkg::SPM_LIGHT_WAKE1:
        begin
          wait_q  <= retain_q ? 17'h00000 : 17'(CPU_RST_CYC - 1);
          state_q <= (state_q == spm_pkg::SPM_DEEP_WAKE1) ? spm_pkg::SPM_DEEP_WAKE2
                                                          : spm_pkg::SPM_LIGHT_WAKE2;
        end
        spm_pkg::SPM_DEEP_WAKE2, spm_pkg::SPM_LIGHT_WAKE2:
          if (wait_q == 17'h00000)
            state_q <= (state_q == spm_pkg::SPM_DEEP_WAKE2) ? spm_pkg::SPM_DEEP_WAKE3
                                                            : spm_pkg::SPM_LIGHT_WAKE3;
          else
            wait_q <= wait_q - 17'h00001;
        spm_pkg::SPM_DEEP_WAKE3, spm_pkg::SPM_LIGHT_WAKE3:
          if (armed_q && !sync_q)
          begin
            armed_q <= 1'b0;
            state_q <= spm_pkg::SPM_RUN;
          end
        default:
          state_q <= spm_pkg::SPM_RUN;
      endcase
    end
  end

  // Registered power, reset and interrupt outputs
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      pwr_q     <= `SPM_PWR_RUN;
      cpu_rst_q <= 1'b0;
      irq_q     <= 1'b0;
    end
    else
    begin
      pwr_q     <= spm_pwr(state_q);
      cpu_rst_q <= !retain_q && ((state_q == spm_pkg::SPM_DEEP_WAKE2) ||
                                 (state_q == spm_pkg::SPM_LIGHT_WAKE2));
      irq_q     <= ien_q && tmr_evt_q;
    end
  end

  assign {MODEM_ACCEL_CLK_EN_OUT, CPU_CLK_EN_OUT, SEQ_CLK_REF_OUT, PAD_RING_EN_OUT, CPU_RAM_CONNECT_OUT,
          DIG_REG_EN_OUT, REFOSC_EN_OUT, REFOSC_REG_EN_OUT, VREF_EN_OUT} = pwr_q;
  assign CPU_RST_OUT        = cpu_rst_q;
  assign RADIO_EN_OUT       = radio_q;
  assign CPU_PRESC_OUT      = presc_q;
  assign WAKE_TIMER_IRQ_OUT = irq_q;
  assign PRDATA_OUT         = prdata_q;
  assign PREADY_OUT         = pready_q;
  assign PSLVERR_OUT        = pslverr_q;

  // Checks of the sequence
  property p_idle_defaults;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (w3_st && armed_q && !sync_q) |=> (!radio_q && presc_q == 4'h0 && state_q == spm_pkg::SPM_RUN);
  endproperty
  a_idle_defaults: assert property (p_idle_defaults) else $error("idle defaults not restored");
  property p_deep_first;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (state_q == spm_pkg::SPM_RUN && sc_q == 2'h3) |=> state_q == spm_pkg::SPM_DEEP_PRE;
  endproperty
  a_deep_first: assert property (p_deep_first) else $error("deep request not preferred");
  property p_light_entry;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (state_q == spm_pkg::SPM_RUN && sc_q == 2'h2) |=> state_q == spm_pkg::SPM_LIGHT_PRE;
  endproperty
  a_light_entry: assert property (p_light_entry) else $error("light request not taken");
  property p_pre_sync;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (pre_st && sync_set) |=> (sync_q && tif.count == 32'h0000_0000);
  endproperty
  a_pre_sync: assert property (p_pre_sync) else $error("pre-entry sync or restart missing");
  property p_deep_off;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (state_q == spm_pkg::SPM_DEEP_PRE && armed_q && !sync_q) |=> ##1 pwr_q == 9'h000;
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("deep sleep not powered down");
  property p_deep_osc;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (state_q == spm_pkg::SPM_DEEP_SLEEP && wake) |=> ##1 pwr_q == 9'h007;
  endproperty
  a_deep_osc: assert property (p_deep_osc) else $error("deep wake supplies wrong");
  property p_cpu_reset;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    ($rose(state_q == spm_pkg::SPM_DEEP_WAKE2) && !retain_q) |=> CPU_RST_OUT [*8];
  endproperty
  a_cpu_reset: assert property (p_cpu_reset) else $error("cpu reset not applied");
  property p_modem_on;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (w3_st && armed_q && !sync_q) |=> ##1 MODEM_ACCEL_CLK_EN_OUT;
  endproperty
  a_modem_on: assert property (p_modem_on) else $error("modem clock not enabled");
  property p_no_timer_wake;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    (state_q == spm_pkg::SPM_LIGHT_SLEEP && !tmr_en_q && !EXT_WAKE_IN && !(rtc_en_q && RTC_TIMEOUT_IN))
      |=> state_q == spm_pkg::SPM_LIGHT_SLEEP;
  endproperty
  a_no_timer_wake: assert property (p_no_timer_wake) else $error("wake without enabled source");
  property p_sync_set;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
    $rose(sync_q) |-> $past(pre_st || w3_st);
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync flag set outside entry or wake");
  c_deep_loop: cover property (@(posedge MCLK_IN) state_q == spm_pkg::SPM_DEEP_WAKE3 ##1 state_q == spm_pkg::SPM_RUN);
  c_light_loop: cover property (@(posedge MCLK_IN) state_q == spm_pkg::SPM_LIGHT_WAKE3 ##1 state_q == spm_pkg::SPM_RUN);
  c_timer_irq: cover property (@(posedge MCLK_IN) $rose(WAKE_TIMER_IRQ_OUT));
endmodule
`default_nettype wire

// *** sleep_power_mode_sequencer_test.sv ***
// Self-checking bench for the sleep power mode sequencer
`timescale 1ns/100ps
`default_nettype none
`include "spm_params.svh"
module sleep_power_mode_sequencer_test;
  localparam int OSC_CYC = 20;
  localparam int RST_CYC = 10;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_wake;
  logic        rtc_to;
  wire  [8:0]  pwr;
  logic        cpu_rst;
  logic        radio;
  logic        irq;
  logic [3:0]  presc;
  logic [9:0]  obs;
  logic [31:0] rdat;
  logic        rerr;
  int          mismatches;
  int          n_compared;
  int          hi_cnt;
  int          wait_n;
  // Power enables and CPU reset seen as one vector
  assign obs = {cpu_rst, pwr};
  // Design with shortened counts
  spm_sequencer #(.DEEP_TICK_DIV(4), .OSC_WAIT_CYC(OSC_CYC), .CPU_RST_CYC(RST_CYC)) DUT (
    .MCLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .EXT_WAKE_IN(ext_wake), .RTC_TIMEOUT_IN(rtc_to), .VREF_EN_OUT(pwr[0]), .REFOSC_REG_EN_OUT(pwr[1]),
    .REFOSC_EN_OUT(pwr[2]), .DIG_REG_EN_OUT(pwr[3]), .CPU_RAM_CONNECT_OUT(pwr[4]), .PAD_RING_EN_OUT(pwr[5]),
    .SEQ_CLK_REF_OUT(pwr[6]), .CPU_CLK_EN_OUT(pwr[7]), .MODEM_ACCEL_CLK_EN_OUT(pwr[8]),
    .CPU_RST_OUT(cpu_rst), .RADIO_EN_OUT(radio), .CPU_PRESC_OUT(presc), .WAKE_TIMER_IRQ_OUT(irq));
  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Verdict and end of run
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bound ran out
  task hang;
    mismatches++;
    complete_run();
  endtask
  // Compare seen against expected
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      hang();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read and compare
  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rdat, exp);
  endtask
  // Wait for one observed bit, counting cycles and CPU reset cycles
  task wait_bit(input int b, input logic v);
    hi_cnt = 0;
    wait_n = 0;
    while (obs[b] !== v)
    begin
      @(posedge clk);
      wait_n++;
      if (obs[9] === 1'b1)
        hi_cnt++;
      if (wait_n > 6000)
        hang();
    end
  endtask
  // Poll the sync flag
  task wait_sync;
    int n;
    rdat = 32'h0;
    for (n = 0; n < 200 && rdat[0] !== 1'b1; n++)
      apb(1'b0, `SPM_OFF_STATUS, 32'h0);
    if (rdat[0] !== 1'b1)
      hang();
  endtask
  // Full entry, sleep and wake loop
  task sleep_loop(input string name, input logic deep, input logic [31:0] opt, input logic [31:0] wctl,
                  input logic [9:0] asleep, input logic [9:0] step1, input int rexp, input logic [31:0] st);
    apb(1'b1, `SPM_OFF_TIMEOUT, 32'h20);
    apb(1'b1, `SPM_OFF_WAKE_CTL, wctl);
    apb(1'b1, `SPM_OFF_OPTIONS, opt);
    repeat (2) @(posedge clk);
    chk("presc", {28'h0, presc}, {28'h0, opt[7:4]});
    chk("radio", {31'h0, radio}, 32'h1);
    apb(1'b1, `SPM_OFF_SLEEP_CTL, deep ? 32'h3 : 32'h2);
    wait_sync();
    chk("pre_pwr", {22'h0, obs}, 32'h1ff);
    apb(1'b1, `SPM_OFF_STATUS, 32'h1);
    repeat (4) @(posedge clk);
    chk("asleep", {22'h0, obs}, {22'h0, asleep});
    if (!deep)
    begin
      repeat (4500) @(posedge clk);
      chk("no_tmr_wake", {22'h0, obs}, {22'h0, asleep});
      rtc_to <= 1'b1;
    end
    else if (!wctl[`SPM_WC_TMR_EN])
      ext_wake <= 1'b1;
    wait_bit(0, 1'b1);
    rtc_to <= 1'b0;
    ext_wake <= 1'b0;
    chk("osc_up", {22'h0, obs}, 32'h7);
    wait_bit(3, 1'b1);
    chk("osc_wait", 32'(wait_n >= OSC_CYC - 1 && wait_n <= OSC_CYC + 1), 32'h1);
    chk("step1", {22'h0, obs}, {22'h0, step1});
    wait_bit(7, 1'b1);
    chk("cpu_rst", 32'(rexp == 0 ? hi_cnt == 0 : hi_cnt >= rexp - 1 && hi_cnt <= rexp + 1), 32'h1);
    wait_sync();
    chk("no_modem", {31'h0, obs[8]}, 32'h0);
    apb(1'b1, `SPM_OFF_STATUS, 32'h1);
    wait_bit(8, 1'b1);
    chk("idle", {27'h0, radio, presc}, 32'h0);
    rd_chk("status", `SPM_OFF_STATUS, st);
    chk("irq", {31'h0, irq}, {31'h0, wctl[16]});
    apb(1'b1, `SPM_OFF_STATUS, 32'h1e);
    rd_chk("st_clr", `SPM_OFF_STATUS, 32'h0);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    $display("test %s done", name);
  endtask
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_wake = 1'b0;
    rtc_to = 1'b0;
    mismatches = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("rst_pwr", {22'h0, obs}, 32'h1ff);
    chk("rst_idle", {27'h0, radio, presc}, 32'h0);
    rd_chk("sleep_ctl", `SPM_OFF_SLEEP_CTL, 32'h0);
    rd_chk("status0", `SPM_OFF_STATUS, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, rerr}, 32'h1);
    chk("unmapped_rd", rdat, 32'h0);
    $display("test reset done");
    sleep_loop("deep", 1'b1, 32'h32, 32'h10001, 10'h000, 10'h07f, RST_CYC, 32'h12);
    sleep_loop("light", 1'b0, 32'h13, 32'h2, 10'h006, 10'h03f, 0, 32'h14);
    sleep_loop("ext", 1'b1, 32'h53, 32'h0, 10'h000, 10'h07f, 0, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
